// ### verilog/fpec_flash_ctrl.sv
// Flash program and erase sequencer with its register file.
//
// Notes on behaviour
// - While busy, only interrupt register writes land.
// - Start while busy is refused, sets access fail.
// - Erase key selects none, page or mass.
// - Erase key returns to zero after erase.
// - Page start bit erases page, reads 1 meanwhile.
// - Mass start bit erases all, self clears.
// - Program start bit writes staged word.
// - Start bits cannot be cleared by software.
// - Access fail enable gates interrupt.
// - Completion enable gates interrupt.
// - Access fail set by hardware, cleared writing 0.
// - Completion flag set at finish, cleared writing 0.
// - ECC capture holds odd and even codes.
// - Four staging words form the 128-bit word.
// - Info block opens only after key written.
// - Interrupt when any enabled flag is set.
// - Any other unlock value refuses that write's start, sets access fail.
// - Low address bits ignored for alignment.
// - Busy set during erase, cleared at completion.
`timescale 1ns/100ps
`default_nettype none

module fpec_flash_ctrl
	import fpec_pkg::*;
#(
	parameter int PROG_TIME_US = 60,
	parameter int PAGE_TIME_US = 20000,
	parameter int MASS_TIME_US = 40000,
	parameter logic [31:0] INFO_KEY = 32'h3c5a_0f96
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output fpec_cmd_type flash_cmd,
	input wire fpec_rd_type flash_rd,
	output logic info_access_en,
	output logic flash_irq
);

	localparam int TICK_W = 24;
	localparam logic [TICK_W-1:0] PROG_TICKS = TICK_W'(PROG_TIME_US * FPEC_TICK_MHZ);
	localparam logic [TICK_W-1:0] PAGE_TICKS = TICK_W'(PAGE_TIME_US * FPEC_TICK_MHZ);
	localparam logic [TICK_W-1:0] MASS_TICKS = TICK_W'(MASS_TIME_US * FPEC_TICK_MHZ);

	// ==========================================================
	// Helpers
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	function automatic logic [31:0] align(input logic [31:0] a, input int bits);
		logic [31:0] mask;
		mask = 32'hffff_ffff << bits;
		align = a & mask;
	endfunction

	// ==========================================================
	// Reset release
	logic rst_meta_ff;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Register storage
	fpec_op_type state_ff;
	fpec_op_type nxt_state;
	logic [31:0] addr_ff;
	logic [31:0] nxt_addr;
	logic [7:0] clkdiv_ff;
	logic [7:0] nxt_clkdiv;
	logic [3:0] unlock_ff;
	logic [3:0] nxt_unlock;
	logic [7:0] ecode_ff;
	logic [7:0] nxt_ecode;
	logic af_ff;
	logic nxt_af;
	logic done_ff;
	logic nxt_done;
	logic afie_ff;
	logic nxt_afie;
	logic doneie_ff;
	logic nxt_doneie;
	logic [17:0] ecc_ff;
	logic [17:0] nxt_ecc;
	logic [31:0] data_ff [4];
	logic [31:0] nxt_data [4];
	logic [31:0] info_ff;
	logic [31:0] nxt_info;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;

	// ==========================================================
	// Write decode
	logic busy;
	logic wr_ok;
	logic wr_addr;
	logic wr_clkdiv;
	logic wr_ctrl;
	logic wr_irq;
	logic wr_info;
	logic ctl_attempt;

	assign busy = (state_ff != FPEC_IDLE);
	assign wr_ok = reg_wr && !busy;
	assign wr_addr = wr_ok && hit(reg_addr, FPEC_OFF_ADDR);
	assign wr_clkdiv = wr_ok && hit(reg_addr, FPEC_OFF_CLKDIV);
	assign wr_ctrl = wr_ok && hit(reg_addr, FPEC_OFF_CTRL);
	assign wr_irq = reg_wr && hit(reg_addr, FPEC_OFF_IRQ);
	assign wr_info = wr_ok && hit(reg_addr, FPEC_OFF_INFO);
	assign ctl_attempt = reg_wr && hit(reg_addr, FPEC_OFF_CTRL);

	// ==========================================================
	// Start request evaluation
	logic [3:0] w_unlock;
	logic [7:0] w_ecode;
	logic w_unlocked;
	logic req_page;
	logic req_mass;
	logic req_prog;
	logic req_any;
	logic key_bad;
	logic fail;
	logic go;
	fpec_op_type go_op;
	logic op_done;
	logic erase_done;
	logic [TICK_W-1:0] go_ticks;

	assign w_unlock = reg_wdata[FPEC_CTL_UNLOCK_LSB +: 4];
	assign w_unlocked = (w_unlock == FPEC_UNLOCK_KEY);
	// The erase key only lands when the same write carries the unlock key; an earlier unlock does not count.
	assign w_ecode = w_unlocked ? reg_wdata[FPEC_CTL_ECODE_LSB +: 8] : ecode_ff;
	assign req_page = reg_wdata[FPEC_CTL_PAGE_BIT];
	assign req_mass = reg_wdata[FPEC_CTL_MASS_BIT];
	assign req_prog = reg_wdata[FPEC_CTL_PROG_BIT];
	assign req_any = ctl_attempt && (req_page || req_mass || req_prog);
	assign key_bad = req_mass ? (w_ecode != FPEC_ECODE_MASS) :
		(req_page && (w_ecode != FPEC_ECODE_PAGE));
	assign fail = req_any && (busy || !w_unlocked || key_bad);
	assign go = req_any && !fail;
	// Mass erase outranks page erase, which outranks programming, when several bits arrive together.
	assign go_op = req_mass ? FPEC_MASS : (req_page ? FPEC_PAGE : FPEC_PROG);
	assign go_ticks = (go_op == FPEC_MASS) ? MASS_TICKS :
		((go_op == FPEC_PAGE) ? PAGE_TICKS : PROG_TICKS);
	assign erase_done = op_done && ((state_ff == FPEC_PAGE) || (state_ff == FPEC_MASS));

	fpec_op_timer #(
		.TICK_W(TICK_W)
	) u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.start(go),
		.clkdiv(clkdiv_ff),
		.ticks(go_ticks),
		.done(op_done)
	);

	// ==========================================================
	// Next-state logic
	// Start bits live only in the state, so software can raise but never lower them.
	assign nxt_state = go ? go_op : (op_done ? FPEC_IDLE : state_ff);
	assign nxt_addr = wr_addr ? reg_wdata : addr_ff;
	assign nxt_clkdiv = wr_clkdiv ? reg_wdata[7:0] : clkdiv_ff;
	assign nxt_unlock = wr_ctrl ? w_unlock : unlock_ff;
	assign nxt_ecode = erase_done ? FPEC_ECODE_NONE : (wr_ctrl ? w_ecode : ecode_ff);
	// A hardware event in the same cycle as a software clear wins.
	assign nxt_af = fail ? 1'b1 : (wr_irq ? (af_ff & reg_wdata[FPEC_IRQ_AF_BIT]) : af_ff);
	assign nxt_done = op_done ? 1'b1 : (wr_irq ? (done_ff & reg_wdata[FPEC_IRQ_DONE_BIT]) : done_ff);
	assign nxt_afie = wr_irq ? reg_wdata[FPEC_IRQ_AFIE_BIT] : afie_ff;
	assign nxt_doneie = wr_irq ? reg_wdata[FPEC_IRQ_DONEIE_BIT] : doneie_ff;
	assign nxt_ecc = flash_rd.valid ? {flash_rd.ecc_odd, flash_rd.ecc_even} : ecc_ff;
	assign nxt_info = wr_info ? reg_wdata : info_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_data
			assign nxt_data[gi] = (wr_ok && hit(reg_addr, FPEC_OFF_DATA0 + 8'(4 * gi))) ?
				reg_wdata : data_ff[gi];
		end
	endgenerate

	// ==========================================================
	// Read path
	logic [31:0] ctrl_view;
	logic [31:0] irq_view;
	logic [31:0] ecc_view;
	logic [31:0] rd_mux;

	assign ctrl_view = {unlock_ff, 3'b000, busy, 8'h00, ecode_ff, 5'b00000,
		state_ff == FPEC_PAGE, state_ff == FPEC_MASS, state_ff == FPEC_PROG};
	assign irq_view = {22'h000000, afie_ff, doneie_ff, 6'h00, af_ff, done_ff};
	assign ecc_view = {7'h00, ecc_ff[17:9], 7'h00, ecc_ff[8:0]};
	assign rd_mux = hit(reg_addr, FPEC_OFF_ADDR) ? addr_ff :
		hit(reg_addr, FPEC_OFF_CLKDIV) ? {24'h000000, clkdiv_ff} :
		hit(reg_addr, FPEC_OFF_CTRL) ? ctrl_view :
		hit(reg_addr, FPEC_OFF_IRQ) ? irq_view :
		hit(reg_addr, FPEC_OFF_ECC) ? ecc_view :
		hit(reg_addr, FPEC_OFF_DATA0) ? data_ff[0] :
		hit(reg_addr, FPEC_OFF_DATA1) ? data_ff[1] :
		hit(reg_addr, FPEC_OFF_DATA2) ? data_ff[2] :
		hit(reg_addr, FPEC_OFF_DATA3) ? data_ff[3] :
		hit(reg_addr, FPEC_OFF_INFO) ? info_ff :
		FPEC_RST_ZERO;
	assign nxt_rdata = reg_rd ? rd_mux : FPEC_RST_ZERO;

	// ==========================================================
	// Outputs
	assign reg_rdata = rdata_ff;
	assign flash_cmd.op = state_ff;
	assign flash_cmd.addr = (state_ff == FPEC_PAGE) ? align(addr_ff, FPEC_PAGE_ALIGN_BITS) :
		align(addr_ff, FPEC_WORD_ALIGN_BITS);
	assign flash_cmd.data = {data_ff[3], data_ff[2], data_ff[1], data_ff[0]};
	// The key is compared in full every cycle, so any later rewrite with another value closes the block again.
	assign info_access_en = (info_ff == INFO_KEY);
	assign flash_irq = (af_ff && afie_ff) || (done_ff && doneie_ff);

	// ==========================================================
	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= FPEC_IDLE;
			addr_ff <= FPEC_RST_ZERO;
			clkdiv_ff <= FPEC_RST_CLKDIV;
			unlock_ff <= 4'h0;
			ecode_ff <= FPEC_ECODE_NONE;
			af_ff <= 1'b0;
			done_ff <= 1'b0;
			afie_ff <= 1'b0;
			doneie_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			clkdiv_ff <= nxt_clkdiv;
			unlock_ff <= nxt_unlock;
			ecode_ff <= nxt_ecode;
			af_ff <= nxt_af;
			done_ff <= nxt_done;
			afie_ff <= nxt_afie;
			doneie_ff <= nxt_doneie;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ecc_ff <= 18'h00000;
			info_ff <= FPEC_RST_ZERO;
			rdata_ff <= FPEC_RST_ZERO;
			for (int i = 0; i < 4; i++) begin
				data_ff[i] <= FPEC_RST_ZERO;
			end
		end else begin
			ecc_ff <= nxt_ecc;
			info_ff <= nxt_info;
			rdata_ff <= nxt_rdata;
			for (int i = 0; i < 4; i++) begin
				data_ff[i] <= nxt_data[i];
			end
		end
	end

endmodule

`default_nettype wire

// ### common/fpec_pkg.sv
// Package of register map, field layout, encodings and carrier types for the flash sequencer.
package fpec_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] FPEC_OFF_ADDR = 8'h00;
	localparam logic [7:0] FPEC_OFF_CLKDIV = 8'h04;
	localparam logic [7:0] FPEC_OFF_CTRL = 8'h08;
	localparam logic [7:0] FPEC_OFF_IRQ = 8'h24;
	localparam logic [7:0] FPEC_OFF_ECC = 8'h28;
	localparam logic [7:0] FPEC_OFF_DATA0 = 8'h30;
	localparam logic [7:0] FPEC_OFF_DATA1 = 8'h34;
	localparam logic [7:0] FPEC_OFF_DATA2 = 8'h38;
	localparam logic [7:0] FPEC_OFF_DATA3 = 8'h3c;
	localparam logic [7:0] FPEC_OFF_INFO = 8'h40;

	// ==========================================================
	// Control register fields
	localparam int FPEC_CTL_UNLOCK_LSB = 28;
	localparam int FPEC_CTL_BUSY_BIT = 24;
	localparam int FPEC_CTL_ECODE_LSB = 8;
	localparam int FPEC_CTL_PAGE_BIT = 2;
	localparam int FPEC_CTL_MASS_BIT = 1;
	localparam int FPEC_CTL_PROG_BIT = 0;
	localparam logic [3:0] FPEC_UNLOCK_KEY = 4'h2;
	localparam logic [7:0] FPEC_ECODE_NONE = 8'h00;
	localparam logic [7:0] FPEC_ECODE_PAGE = 8'h55;
	localparam logic [7:0] FPEC_ECODE_MASS = 8'haa;

	// ==========================================================
	// Interrupt register fields
	localparam int FPEC_IRQ_AFIE_BIT = 9;
	localparam int FPEC_IRQ_DONEIE_BIT = 8;
	localparam int FPEC_IRQ_AF_BIT = 1;
	localparam int FPEC_IRQ_DONE_BIT = 0;

	// ==========================================================
	// ECC capture fields and address alignment
	localparam int FPEC_ECC_ODD_LSB = 16;
	localparam int FPEC_ECC_EVEN_LSB = 0;
	localparam int FPEC_WORD_ALIGN_BITS = 4;
	localparam int FPEC_PAGE_ALIGN_BITS = 13;

	// ==========================================================
	// Reset values and timing
	localparam logic [31:0] FPEC_RST_ZERO = 32'h0000_0000;
	localparam logic [7:0] FPEC_RST_CLKDIV = 8'h60;
	localparam int FPEC_TICK_MHZ = 1;

	// ==========================================================
	// Operation codes and carriers
	typedef enum logic [1:0] {
		FPEC_IDLE = 2'b00,
		FPEC_PROG = 2'b01,
		FPEC_MASS = 2'b10,
		FPEC_PAGE = 2'b11
	} fpec_op_type;

	typedef struct packed {
		fpec_op_type op;
		logic [31:0] addr;
		logic [127:0] data;
	} fpec_cmd_type;

	typedef struct packed {
		logic valid;
		logic [8:0] ecc_odd;
		logic [8:0] ecc_even;
	} fpec_rd_type;

endpackage

// ### verilog/fpec_op_timer.sv
// Operation timer that derives the program clock tick and counts an operation's duration.
`timescale 1ns/100ps
`default_nettype none

module fpec_op_timer
	import fpec_pkg::*;
#(
	parameter int TICK_W = 24
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] clkdiv,
	input wire logic [TICK_W-1:0] ticks,
	output logic done
);

	// ==========================================================
	// Divider and tick counter
	logic running_ff;
	logic nxt_running;
	logic [7:0] div_ff;
	logic [7:0] nxt_div;
	logic [TICK_W-1:0] tick_ff;
	logic [TICK_W-1:0] nxt_tick;
	logic tick_edge;

	// A divisor of zero is treated as one so that an operation can never hang.
	assign tick_edge = running_ff && (div_ff <= 8'h01);
	assign done = tick_edge && (tick_ff <= {{(TICK_W-1){1'b0}}, 1'b1});
	assign nxt_running = start ? 1'b1 : (done ? 1'b0 : running_ff);
	assign nxt_div = (start || tick_edge) ? clkdiv : div_ff - 8'h01;
	assign nxt_tick = start ? ticks : (tick_edge ? tick_ff - {{(TICK_W-1){1'b0}}, 1'b1} : tick_ff);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			running_ff <= 1'b0;
			div_ff <= FPEC_RST_CLKDIV;
			tick_ff <= '0;
		end else begin
			running_ff <= nxt_running;
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end

endmodule

`default_nettype wire

// ### testbench/fpec_flash_ctrl_asserts.sv
// Port checks for the flash sequencer.
`timescale 1ns/100ps
`default_nettype none
module fpec_flash_ctrl_asserts
	import fpec_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire fpec_cmd_type flash_cmd,
	input wire fpec_rd_type flash_rd,
	input wire logic info_access_en,
	input wire logic flash_irq
);
	// ==========================================================
	// Decodes and sequences
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire idle = flash_cmd.op == FPEC_IDLE;
	wire ctl_wr = reg_wr && reg_addr == FPEC_OFF_CTRL && idle;
	wire key_ok = reg_wdata[31:28] == FPEC_UNLOCK_KEY;
	wire info_wr = reg_wr && reg_addr == FPEC_OFF_INFO;
	sequence s_code_seen;
		flash_rd.valid;
	endsequence
	sequence s_ecc_read;
		s_code_seen ##1 (reg_rd && reg_addr == FPEC_OFF_ECC && !flash_rd.valid);
	endsequence
	// ==========================================================
	// Assertions
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_locked_refuse: assert property (ctl_wr && !key_ok |=> idle)
		else $error("operation started while locked");
	a_prog_start: assert property (ctl_wr && key_ok && reg_wdata[2:0] == 3'b001 |=> flash_cmd.op == FPEC_PROG)
		else $error("program did not start");
	a_mass_start: assert property (ctl_wr && key_ok && reg_wdata[1] && reg_wdata[15:8] == FPEC_ECODE_MASS
		|=> flash_cmd.op == FPEC_MASS)
		else $error("mass erase did not start");
	a_page_badkey: assert property (ctl_wr && reg_wdata[2:0] == 3'b100 && reg_wdata[15:8] != FPEC_ECODE_PAGE |=> idle)
		else $error("page erase started with wrong key");
	a_prog_align: assert property (flash_cmd.op == FPEC_PROG |-> flash_cmd.addr[3:0] == 4'h0)
		else $error("program address not word aligned");
	a_page_align: assert property (flash_cmd.op == FPEC_PAGE |-> flash_cmd.addr[12:0] == 13'h0)
		else $error("page address not page aligned");
	a_op_steady: assert property (!idle |=> idle || $stable(flash_cmd))
		else $error("command changed during operation");
	a_ecc_capture: assert property (s_ecc_read |=> reg_rdata == {7'h0, $past(flash_rd.ecc_odd, 2), 7'h0,
		$past(flash_rd.ecc_even, 2)})
		else $error("check codes not captured");
	a_info_open: assert property ($rose(info_access_en) |-> $past(info_wr))
		else $error("info block opened without a write");
endmodule
`default_nettype wire

// ### testbench/fpec_flash_model.sv
// Behavioural flash array read port feeding check codes back.
`timescale 1ns/100ps
`default_nettype none
module fpec_flash_model
	import fpec_pkg::*;
(
	input wire logic clk,
	input wire fpec_cmd_type flash_cmd,
	input wire logic rd_go,
	input wire logic [8:0] rd_odd,
	input wire logic [8:0] rd_even,
	output fpec_rd_type flash_rd
);
	// ==========================================================
	// Read port
	// The array cannot be read while it programs; codes toggle between reads so stale values never look settled.
	wire rd_ok = rd_go && flash_cmd.op == FPEC_IDLE;
	initial flash_rd = '0;
	always @(posedge clk) begin
		flash_rd.valid <= rd_ok;
		flash_rd.ecc_odd <= rd_ok ? rd_odd : ~flash_rd.ecc_odd;
		flash_rd.ecc_even <= rd_ok ? rd_even : ~flash_rd.ecc_even;
	end
endmodule
`default_nettype wire

// ### testbench/fpec_flash_ctrl_tb.sv
// Self-checking testbench for the flash sequencer.
`timescale 1ns/100ps
`default_nettype none
module fpec_flash_ctrl_tb
	import fpec_pkg::*;
;
	// ==========================================================
	// Signals and instances
	localparam logic [31:0] KEY = 32'h1234_5678;
	localparam logic [127:0] DAT = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
	localparam logic [7:0] OFFS [8] = '{8'h00, 8'h08, 8'h24, 8'h28, 8'h30, 8'h3c, 8'h40, 8'h0c};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic rd_go = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] rv;
	logic info_access_en;
	logic flash_irq;
	fpec_cmd_type flash_cmd;
	fpec_rd_type flash_rd;
	int n_fail = 0;
	int tests_run = 0;
	initial forever #5 clk = ~clk;
	fpec_flash_ctrl #(.PROG_TIME_US(20), .PAGE_TIME_US(30), .MASS_TIME_US(40), .INFO_KEY(KEY)) u_dut (.clk(clk),
		.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flash_cmd(flash_cmd), .flash_rd(flash_rd), .info_access_en(info_access_en),
		.flash_irq(flash_irq));
	fpec_flash_model u_flash (.clk(clk), .flash_cmd(flash_cmd), .rd_go(rd_go), .rd_odd(9'h1a5), .rd_even(9'h05a),
		.flash_rd(flash_rd));
	// ==========================================================
	// Bus tasks
	task automatic report_and_stop;
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [191:0] got, input logic [191:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic do_chk = 1'b1);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		if (do_chk) chk(rv, exp);
	endtask
	// Polling is bounded so a stuck busy flag ends in a mismatch, not a hang.
	task automatic wait_done(input logic [31:0] exp);
		rv = 32'h0100_0000;
		for (int i = 0; i < 100 && rv[24] !== 1'b0; i++) rc(FPEC_OFF_CTRL, 32'h0, 1'b0);
		chk(rv, exp);
	endtask
	// ==========================================================
	// Tests
	initial begin
		#100000 n_fail++;
		report_and_stop;
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rc(FPEC_OFF_CLKDIV, 32'h60);
		for (int i = 0; i < 8; i++) rc(OFFS[i], 32'h0);
		wr(FPEC_OFF_CLKDIV, 32'h2);
		wr(FPEC_OFF_ADDR, 32'h1000_123f);
		for (int i = 0; i < 4; i++) wr(FPEC_OFF_DATA0 + 8'(4 * i), 32'(32'h1111_1111 * (i + 1)));
		wr(FPEC_OFF_CTRL, 32'h3000_0001);
		chk(flash_cmd.op, FPEC_IDLE);
		rc(FPEC_OFF_IRQ, 32'h2);
		wr(FPEC_OFF_IRQ, 32'h2);
		rc(FPEC_OFF_IRQ, 32'h2);
		wr(FPEC_OFF_IRQ, 32'h300);
		wr(FPEC_OFF_CTRL, 32'h2000_0001);
		chk(flash_cmd, {FPEC_PROG, 32'h1000_1230, DAT});
		rc(FPEC_OFF_CTRL, 32'h2100_0001);
		wr(FPEC_OFF_DATA0, 32'hdead_beef);
		wr(FPEC_OFF_CTRL, 32'h2000_0001);
		rc(FPEC_OFF_DATA0, 32'h1111_1111);
		// Programming takes a divisor of 2 times 20 ticks, so it ends at the fortieth edge after the start.
		repeat (31) @(posedge clk);
		#1 chk(flash_cmd.op, FPEC_PROG);
		@(posedge clk);
		#1 chk(flash_cmd.op, FPEC_IDLE);
		wait_done(32'h2000_0000);
		rc(FPEC_OFF_IRQ, 32'h303);
		chk(flash_irq, 1'b1);
		wr(FPEC_OFF_IRQ, 32'h003);
		chk(flash_irq, 1'b0);
		wr(FPEC_OFF_IRQ, 32'h201);
		chk(flash_irq, 1'b0);
		wr(FPEC_OFF_IRQ, 32'h101);
		chk(flash_irq, 1'b1);
		wr(FPEC_OFF_IRQ, 32'h0);
		wr(FPEC_OFF_CTRL, 32'h2000_aa04);
		chk(flash_cmd.op, FPEC_IDLE);
		rc(FPEC_OFF_IRQ, 32'h2);
		wr(FPEC_OFF_IRQ, 32'h202);
		chk(flash_irq, 1'b1);
		wr(FPEC_OFF_IRQ, 32'h0);
		wr(FPEC_OFF_CTRL, 32'h2000_5504);
		chk({flash_cmd.op, flash_cmd.addr}, {FPEC_PAGE, 32'h1000_0000});
		rc(FPEC_OFF_CTRL, 32'h2100_5504);
		wait_done(32'h2000_0000);
		rc(FPEC_OFF_IRQ, 32'h1);
		wr(FPEC_OFF_IRQ, 32'h0);
		wr(FPEC_OFF_CTRL, 32'h2000_aa02);
		chk(flash_cmd.op, FPEC_MASS);
		wr(FPEC_OFF_CTRL, 32'h2000_0000);
		rc(FPEC_OFF_CTRL, 32'h2100_aa02);
		wait_done(32'h2000_0000);
		@(posedge clk);
		rd_go <= 1'b1;
		@(posedge clk);
		rd_go <= 1'b0;
		rc(FPEC_OFF_ECC, 32'h01a5_005a);
		wr(FPEC_OFF_INFO, KEY);
		chk(info_access_en, 1'b1);
		wr(FPEC_OFF_INFO, KEY ^ 32'h1);
		chk(info_access_en, 1'b0);
		report_and_stop;
	end
endmodule
bind fpec_flash_ctrl fpec_flash_ctrl_asserts u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cmd(flash_cmd),
	.flash_rd(flash_rd), .info_access_en(info_access_en), .flash_irq(flash_irq));
`default_nettype wire
